// ---- design/faar_regs.sv ----
// Purpose: Attenuator, enhanced acoustics and freewheel test register bank
// Assumes: Bus strobes one cycle, never together; inputs synchronous to clk_sys
// Notes:   Ramp engine and test timers run here; PWM and tach logic sit outside
`timescale 1ns/1ns
`default_nettype none

module faar_regs #(
    parameter int MS_CYCLES   = faar_pkg::FAAR_MS_CYCLES,
    parameter int SLOT_CYCLES = faar_pkg::FAAR_SLOT_CYCLES
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // Register port
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    // Device control
    input  wire logic             soft_reset,
    input  wire logic             reg_lock,
    input  wire logic [3:0][2:0]  spinup_code,
    input  wire logic [3:0]       slow_ramp,
    input  wire logic [3:0][7:0]  duty_target,
    // Outputs to the analog and fan logic
    output logic      [6:0]       atten_en_a,
    output logic      [4:0]       atten_en_b,
    output logic      [3:0][7:0]  duty_out,
    output logic      [7:0]       fan_test_active
);

    // ==========================================================
    // Helpers
    function automatic logic [7:0] rate_step(input logic [2:0] code);
        case (code)
            3'h0:    rate_step = 8'h01;
            3'h1:    rate_step = 8'h02;
            3'h2:    rate_step = 8'h03;
            3'h3:    rate_step = 8'h05;
            3'h4:    rate_step = 8'h08;
            3'h5:    rate_step = 8'h0C;
            3'h6:    rate_step = 8'h18;
            default: rate_step = 8'h30;
        endcase
    endfunction

    function automatic logic [14:0] fw_duration(input logic [2:0] code);
        case (code)
            3'h0:    fw_duration = faar_pkg::FAAR_FW_MS_000;
            3'h1:    fw_duration = faar_pkg::FAAR_FW_MS_001;
            3'h2:    fw_duration = faar_pkg::FAAR_FW_MS_010;
            3'h3:    fw_duration = faar_pkg::FAAR_FW_MS_011;
            3'h4:    fw_duration = faar_pkg::FAAR_FW_MS_100;
            3'h5:    fw_duration = faar_pkg::FAAR_FW_MS_101;
            3'h6:    fw_duration = faar_pkg::FAAR_FW_MS_110;
            default: fw_duration = faar_pkg::FAAR_FW_MS_111;
        endcase
    endfunction

    function automatic logic [7:0] ramp_field(input logic [7:0] ramp12, input logic [7:0] ramp34,
                                              input int ch);
        logic [7:0] r;
        r = (ch < 2) ? ramp12 : ramp34;
        ramp_field = r;
    endfunction

    faar_pkg::faar_state_t st_reg;
    faar_pkg::faar_state_t st_next;

    logic        wr_ok;
    logic        slot_tick;
    logic        ms_tick;
    logic [7:0]  fw_done;

    // ==========================================================
    // Timebases
    assign slot_tick = (st_reg.slot_cnt == 32'(SLOT_CYCLES - 1));
    assign ms_tick   = (st_reg.ms_cnt == 32'(MS_CYCLES - 1));
    // Lock only guards software writes; timers and self-clear keep running
    assign wr_ok     = reg_wr && !reg_lock;

    // ==========================================================
    // Next state
    always_comb begin
        logic [7:0] rr;
        logic [2:0] code;
        logic       en;
        logic [7:0] step;
        logic [7:0] diff;
        logic [7:0] tgt;
        logic [7:0] cur;
        logic       move;
        logic [7:0] wset;
        logic [2:0] sp;
        rr      = 8'h00;
        code    = 3'h0;
        en      = 1'b0;
        step    = 8'h00;
        diff    = 8'h00;
        tgt     = 8'h00;
        cur     = 8'h00;
        move    = 1'b0;
        wset    = 8'h00;
        sp      = 3'h0;
        fw_done = 8'h00;
        st_next = st_reg;

        st_next.slot_cnt = slot_tick ? 32'h0000_0000 : st_reg.slot_cnt + 32'h0000_0001;
        st_next.ms_cnt   = ms_tick ? 32'h0000_0000 : st_reg.ms_cnt + 32'h0000_0001;

        // Register writes
        if (wr_ok) begin
            case (reg_addr)
                faar_pkg::FAAR_ADDR_ATTEN_A:
                    st_next.atten_a = reg_wdata | faar_pkg::FAAR_ATTEN_A_RO;
                faar_pkg::FAAR_ADDR_ATTEN_B:
                    st_next.atten_b = reg_wdata;
                faar_pkg::FAAR_ADDR_RAMP12:
                    st_next.ramp12 = reg_wdata;
                faar_pkg::FAAR_ADDR_RAMP34:
                    st_next.ramp34 = reg_wdata;
                faar_pkg::FAAR_ADDR_FW_EN:
                    st_next.fw_en = reg_wdata;
                default: begin
                end
            endcase
        end

        // Ramp engine per PWM channel
        for (int ch = 0; ch < 4; ch++) begin
            rr   = ramp_field(st_reg.ramp12, st_reg.ramp34, ch);
            en   = rr[faar_pkg::FAAR_EN_LO_BIT + (ch % 2)];
            code = (ch % 2 == 0) ? rr[faar_pkg::FAAR_RATE_LO_POS +: 3]
                                 : rr[faar_pkg::FAAR_RATE_HI_POS +: 3];
            step = rate_step(code);
            tgt  = duty_target[ch];
            cur  = st_reg.duty[ch];
            if (slot_tick) begin
                st_next.slow_div[ch] = st_reg.slow_div[ch] + 2'h1;
            end
            // Slow mode steps once every fourth slot
            move = slot_tick && (!slow_ramp[ch] ||
                   st_reg.slow_div[ch] == faar_pkg::FAAR_SLOW_LAST);
            if (!en) begin
                st_next.duty[ch] = tgt;
            end else if (move) begin
                if (tgt > cur) begin
                    diff = tgt - cur;
                    st_next.duty[ch] = (diff > step) ? cur + step : tgt;
                end else if (tgt < cur) begin
                    diff = cur - tgt;
                    st_next.duty[ch] = (diff > step) ? cur - step : tgt;
                end
            end
        end

        // Freewheel tests; fan n uses the timeout of PWM channel n mod 4
        wset = (wr_ok && reg_addr == faar_pkg::FAAR_ADDR_FW_START) ? reg_wdata : st_reg.fw_start;
        for (int f = 0; f < 8; f++) begin
            sp = spinup_code[f % 4];
            if (st_reg.fw_start[f] && ms_tick &&
                (st_reg.fw_ms[f] + 15'h0001) >= fw_duration(sp)) begin
                fw_done[f] = 1'b1;
            end
            if (st_reg.fw_start[f] && ms_tick) begin
                st_next.fw_ms[f] = st_reg.fw_ms[f] + 15'h0001;
            end
            if (wr_ok && reg_addr == faar_pkg::FAAR_ADDR_FW_START) begin
                // A new 1 is accepted only for enabled fans; 0 cancels
                st_next.fw_start[f] = wset[f] && (st_reg.fw_en[f] || st_reg.fw_start[f]);
                if (wset[f] && !st_reg.fw_start[f]) begin
                    st_next.fw_ms[f] = 15'h0000;
                end
                if (fw_done[f] && wset[f] && st_reg.fw_en[f]) begin
                    // Restart wins over the self-clear in the same cycle
                    st_next.fw_ms[f] = 15'h0000;
                end else if (fw_done[f]) begin
                    st_next.fw_start[f] = 1'b0;
                end
            end else if (fw_done[f]) begin
                st_next.fw_start[f] = 1'b0;
            end
            if (!st_next.fw_start[f]) begin
                st_next.fw_ms[f] = 15'h0000;
            end
        end

        // Read data stands one cycle after the strobe
        st_next.rdata = st_reg.rdata;
        if (reg_rd) begin
            case (reg_addr)
                faar_pkg::FAAR_ADDR_ATTEN_A:  st_next.rdata = st_reg.atten_a;
                faar_pkg::FAAR_ADDR_ATTEN_B:  st_next.rdata = st_reg.atten_b;
                faar_pkg::FAAR_ADDR_RAMP12:   st_next.rdata = st_reg.ramp12;
                faar_pkg::FAAR_ADDR_RAMP34:   st_next.rdata = st_reg.ramp34;
                faar_pkg::FAAR_ADDR_FW_START: st_next.rdata = st_reg.fw_start;
                faar_pkg::FAAR_ADDR_FW_EN:    st_next.rdata = st_reg.fw_en;
                default:                      st_next.rdata = faar_pkg::FAAR_UNMAPPED_READ;
            endcase
        end

        // Soft reset returns every register to its power-on value
        if (soft_reset) begin
            st_next.atten_a  = faar_pkg::FAAR_RST_ATTEN_A;
            st_next.atten_b  = faar_pkg::FAAR_RST_ATTEN_B;
            st_next.ramp12   = faar_pkg::FAAR_RST_RAMP;
            st_next.ramp34   = faar_pkg::FAAR_RST_RAMP;
            st_next.fw_start = faar_pkg::FAAR_RST_FW;
            st_next.fw_en    = faar_pkg::FAAR_RST_FW;
            st_next.fw_ms    = '0;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_reg          <= '0;
            st_reg.atten_a  <= faar_pkg::FAAR_RST_ATTEN_A;
            st_reg.atten_b  <= faar_pkg::FAAR_RST_ATTEN_B;
            st_reg.ramp12   <= faar_pkg::FAAR_RST_RAMP;
            st_reg.ramp34   <= faar_pkg::FAAR_RST_RAMP;
            st_reg.fw_start <= faar_pkg::FAAR_RST_FW;
            st_reg.fw_en    <= faar_pkg::FAAR_RST_FW;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata       = st_reg.rdata;
    assign atten_en_a      = st_reg.atten_a[7:1];
    assign atten_en_b      = {st_reg.atten_b[5:4], st_reg.atten_b[2:0]};
    assign duty_out        = st_reg.duty;
    assign fan_test_active = st_reg.fw_start;

endmodule

`default_nettype wire

// ---- design/faar_pkg.sv ----
// Purpose: Constants and types for the fan acoustics and attenuator register bank
// Assumes: One clock at 250 MHz, synchronous active-high reset
// Notes:   Summary list below; the register module implements it
//
// Summary of operation
// - Attenuator reg A: bit0 reserved, bits7:1 enables
// - Attenuator reg B: bits 0,1,2,4,5 enables
// - Reg B bits 3,7:6 plain storage, zero
// - Per-channel smooth ramp enable, default off
// - Two 3-bit ramp-rate fields per register
// - Rate code maps to duty step table
// - Reset: attenuator A ones, acoustics zeros
// - Soft reset restores defaults; lock blocks writes
// - Test bit starts test, self-clears when done
// - Test lasts the channel spin-up timeout
// - Slow bit makes ramps four times longer
`default_nettype none

package faar_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] FAAR_ADDR_ATTEN_A  = 8'h18;
    localparam logic [7:0] FAAR_ADDR_ATTEN_B  = 8'h19;
    localparam logic [7:0] FAAR_ADDR_RAMP12   = 8'h1A;
    localparam logic [7:0] FAAR_ADDR_RAMP34   = 8'h1B;
    localparam logic [7:0] FAAR_ADDR_FW_START = 8'h1C;
    localparam logic [7:0] FAAR_ADDR_FW_EN    = 8'h1E;

    // ==========================================================
    // Reset values and field layout
    localparam logic [7:0] FAAR_RST_ATTEN_A   = 8'hFF;
    localparam logic [7:0] FAAR_RST_ATTEN_B   = 8'h37;
    localparam logic [7:0] FAAR_RST_RAMP      = 8'h00;
    localparam logic [7:0] FAAR_RST_FW        = 8'h00;
    localparam logic [7:0] FAAR_ATTEN_A_RO    = 8'h01;
    localparam int         FAAR_EN_LO_BIT     = 0;
    localparam int         FAAR_RATE_LO_POS   = 2;
    localparam int         FAAR_RATE_HI_POS   = 5;
    localparam logic [7:0] FAAR_UNMAPPED_READ = 8'h00;

    // ==========================================================
    // Timing
    localparam int          FAAR_CLK_PERIOD_NS = 4;
    localparam int          FAAR_MS_NS         = 1000000;
    localparam int          FAAR_MS_CYCLES     = FAAR_MS_NS / FAAR_CLK_PERIOD_NS;
    localparam int          FAAR_SLOT_CYCLES   = 250000;
    localparam logic [1:0]  FAAR_SLOW_LAST     = 2'h3;
    localparam logic [14:0] FAAR_FW_MS_000     = 15'h0000;
    localparam logic [14:0] FAAR_FW_MS_001     = 15'h0064;
    localparam logic [14:0] FAAR_FW_MS_010     = 15'h00FA;
    localparam logic [14:0] FAAR_FW_MS_011     = 15'h0190;
    localparam logic [14:0] FAAR_FW_MS_100     = 15'h029B;
    localparam logic [14:0] FAAR_FW_MS_101     = 15'h03E8;
    localparam logic [14:0] FAAR_FW_MS_110     = 15'h07D0;
    localparam logic [14:0] FAAR_FW_MS_111     = 15'h7D00;

    // ==========================================================
    // State carrier
    typedef struct packed {
        logic [7:0]       atten_a;
        logic [7:0]       atten_b;
        logic [7:0]       ramp12;
        logic [7:0]       ramp34;
        logic [7:0]       fw_start;
        logic [7:0]       fw_en;
        logic [3:0][7:0]  duty;
        logic [3:0][1:0]  slow_div;
        logic [31:0]      slot_cnt;
        logic [31:0]      ms_cnt;
        logic [7:0][14:0] fw_ms;
        logic [7:0]       rdata;
    } faar_state_t;

endpackage

`default_nettype wire

// ---- testbench/faar_regs_checker.sv ----
// Purpose: Port assertions for the fan acoustics register bank
// Assumes: One clock, synchronous active-high reset
// Notes:   Duty check watches channel 0 only, to keep the checker small
`timescale 1ns/1ns
`default_nettype none
module faar_regs_checker #(
    parameter int MS_CYCLES   = 10,
    parameter int SLOT_CYCLES = 8
) (
    // Clock and reset
    input wire logic            clk_sys,
    input wire logic            sys_rst,
    // Register port and control
    input wire logic [7:0]      reg_addr,
    input wire logic [7:0]      reg_wdata,
    input wire logic            reg_wr,
    input wire logic            reg_rd,
    input wire logic [7:0]      reg_rdata,
    input wire logic            soft_reset,
    input wire logic            reg_lock,
    input wire logic [3:0][7:0] duty_target,
    // Outputs
    input wire logic [6:0]      atten_en_a,
    input wire logic [4:0]      atten_en_b,
    input wire logic [3:0][7:0] duty_out,
    input wire logic [7:0]      fan_test_active
);
    // ==========================================================
    // Helpers: last-cycle copies so $past only sees plain signals
    logic [7:0] wd_q, ft_q, dq, tq;
    logic       w1c_q, rst_q;
    wire logic  wr_ok = reg_wr && !reg_lock && !soft_reset;
    always_ff @(posedge clk_sys) begin
        wd_q  <= reg_wdata;
        ft_q  <= fan_test_active;
        dq    <= duty_out[0];
        tq    <= duty_target[0];
        w1c_q <= wr_ok && reg_addr == 8'h1C;
        rst_q <= sys_rst;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // Assertions
    rst_vals_a: assert property (disable iff (1'b0) sys_rst |=>
        atten_en_a == 7'h7F && atten_en_b == 5'h1F && fan_test_active == 8'h00)
        else $error("reset values wrong");
    soft_def_a: assert property (soft_reset |=>
        atten_en_a == 7'h7F && atten_en_b == 5'h1F && fan_test_active == 8'h00)
        else $error("soft reset values wrong");
    lock_hold_a: assert property ((reg_lock && !soft_reset)[*2] |=>
        $stable(atten_en_a) && $stable(atten_en_b)) else $error("write landed under lock");
    wr_atten_a: assert property (wr_ok && reg_addr == 8'h18 |=>
        atten_en_a == wd_q[7:1]) else $error("attenuator A write lost");
    wr_attb_a: assert property (wr_ok && reg_addr == 8'h19 |=>
        atten_en_b == {wd_q[5:4], wd_q[2:0]}) else $error("attenuator B write lost");
    rd_atten_a: assert property (reg_rd && !soft_reset && reg_addr == 8'h18 |=>
        reg_rdata == {$past(atten_en_a), 1'b1}) else $error("attenuator A read wrong");
    unmap_rd_a: assert property (reg_rd && reg_addr == 8'h20 |=>
        reg_rdata == 8'h00) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!reg_rd && !soft_reset |=>
        $stable(reg_rdata)) else $error("read data moved without read");
    test_rise_a: assert property (|(fan_test_active & ~ft_q) |->
        w1c_q && (fan_test_active & ~ft_q & ~wd_q) == 8'h00) else $error("test bit rose alone");
    duty_dir_a: assert property (!rst_q |->
        (duty_out[0] >= dq && duty_out[0] <= tq) || (duty_out[0] <= dq && duty_out[0] >= tq))
        else $error("duty moved away from target");
    cover property (w1c_q && |fan_test_active);
    cover property (reg_rd && reg_addr == 8'h20);
    cover property (soft_reset);
endmodule
bind faar_regs faar_regs_checker #(.MS_CYCLES(MS_CYCLES), .SLOT_CYCLES(SLOT_CYCLES)) chk_u (
    .clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .soft_reset,
    .reg_lock, .duty_target, .atten_en_a, .atten_en_b, .duty_out, .fan_test_active);
`default_nettype wire

// ---- testbench/fan_acoustics_attenuator_regs_test.sv ----
// Purpose: Self-checking bench for the fan acoustics register bank
// Assumes: Short time bases, 10 cycles per ms and 8 per slot
// Notes:   Model keeps register images in an array indexed by offset
`timescale 1ns/1ns
`default_nettype none
module fan_acoustics_attenuator_regs_test;
    localparam int MS = 10;
    localparam int SL = 8;
    logic            clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic            soft_reset = 1'b0, reg_lock = 1'b0;
    logic [7:0]      reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, fan_test_active;
    logic [3:0][2:0] spinup_code = 12'h000;
    logic [3:0]      slow_ramp = 4'h0;
    logic [3:0][7:0] duty_target = 32'h00000000, duty_out;
    logic [6:0]      atten_en_a;
    logic [4:0]      atten_en_b;
    logic [31:0]     rnd = 32'hBFA482C1;
    logic [7:0]      mdl [8];
    int              failures = 0, tests_run = 0, cyc = 0;
    int              stp [8] = '{1, 2, 3, 5, 8, 12, 24, 48};
    always #2 clk_sys = ~clk_sys;
    faar_regs #(.MS_CYCLES(MS), .SLOT_CYCLES(SL)) dut_u (.clk_sys, .sys_rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .soft_reset, .reg_lock, .spinup_code,
        .slow_ramp, .duty_target, .atten_en_a, .atten_en_b, .duty_out, .fan_test_active);
    // ==========================================================
    // Tasks
    task automatic finish_test();
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic defaults();
        mdl = '{8'hFF, 8'h37, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    endtask
    task automatic check_all();
        for (int i = 0; i < 8; i++) rdchk(8'h18 + 8'(i), mdl[i]);
        chk({atten_en_a, 1'b1}, mdl[0]);
        chk({3'h0, atten_en_b}, {3'h0, mdl[1][5:4], mdl[1][2:0]});
        rdchk(8'h20, 8'h00);
    endtask
    // Follows one channel until it settles; step and slot spacing both checked
    task automatic ramp(input int ch, input int c);
        int d, tg, e, last, n;
        #1;
        d = duty_out[ch];
        tg = duty_target[ch];
        last = -1;
        for (n = 0; n < 2500 && d != tg; n++) begin
            @(posedge clk_sys);
            #1;
            if (duty_out[ch] != d) begin
                e = (tg > d) ? d + ((tg - d < stp[c]) ? tg - d : stp[c])
                             : d - ((d - tg < stp[c]) ? d - tg : stp[c]);
                chk(duty_out[ch], 8'(e));
                if (last >= 0) chk(8'(n - last), 8'((c >= 4) ? 4 * SL : SL));
                last = n;
                d = duty_out[ch];
            end
        end
        chk(duty_out[ch], 8'(tg));
    endtask
    // ==========================================================
    // Stimulus
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        logic [7:0] v;
        int hi [8];
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        defaults();
        check_all();
        for (int n = 0; n < 12; n++) begin
            rnd = lfsr(rnd);
            v = rnd[7:0];
            wr(8'h18 + 8'(n % 4), v);
            mdl[n % 4] = (n % 4 == 0) ? (v | 8'h01) : v;
        end
        check_all();
        @(posedge clk_sys);
        reg_lock <= 1'b1;
        wr(8'h18, 8'h00);
        wr(8'h19, 8'hC0);
        reg_lock <= 1'b0;
        check_all();
        @(posedge clk_sys);
        soft_reset <= 1'b1;
        @(posedge clk_sys);
        soft_reset <= 1'b0;
        defaults();
        check_all();
        for (int c = 0; c < 8; c++) begin
            @(posedge clk_sys);
            slow_ramp <= (c >= 4) ? 4'(1 << (c % 4)) : 4'h0;
            wr(8'h1A + 8'((c % 4) / 2), (c % 2) ? {3'(c), 5'h02} : {3'h0, 3'(c), 2'h1});
            duty_target[c % 4] <= (c < 4) ? 8'hC8 : 8'h00;
            ramp(c % 4, c);
        end
        wr(8'h1A, 8'h00);
        duty_target[0] <= 8'h5A;
        @(posedge clk_sys);
        #1 chk(duty_out[0], 8'h5A);
        @(posedge clk_sys);
        spinup_code <= {3'h0, 3'h3, 3'h2, 3'h1};
        wr(8'h1C, 8'h69);
        #1 chk(fan_test_active, 8'h00);
        wr(8'h1E, 8'h69);
        wr(8'h1C, 8'h69);
        #1 chk(fan_test_active, 8'h69);
        hi = '{default: 0};
        repeat (4100) begin
            @(posedge clk_sys);
            #1;
            for (int f = 0; f < 8; f++) hi[f] += fan_test_active[f];
        end
        chk(8'(hi[3] <= MS), 8'h01);
        chk(8'(hi[0] >= 99 * MS && hi[0] <= 101 * MS), 8'h01);
        chk(8'(hi[5] >= 249 * MS && hi[5] <= 251 * MS), 8'h01);
        chk(8'(hi[6] >= 399 * MS && hi[6] <= 401 * MS), 8'h01);
        chk(8'(hi[1] + hi[2] + hi[4] + hi[7]), 8'h00);
        rdchk(8'h1C, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
